// *** src/bss_params.svh ***
// Constants for the burner stopped-state sequencer
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH
`define BSS_ADDR_W 4
`define BSS_ADDR_CTRL 4'h0
`define BSS_ADDR_STATUS 4'h1
`define BSS_ADDR_IRQ_STAT 4'h2
`define BSS_ADDR_IRQ_MASK 4'h3
`define BSS_ADDR_RETAIN 4'h4
`define BSS_ADDR_RUN_CMD 4'h5
`define BSS_CTRL_RESTART_BIT 0
`define BSS_CTRL_RESET 8'h00
`define BSS_IRQ_PURGE_BIT 0
`define BSS_IRQ_STATE_BIT 1
`define BSS_IRQ_ALARM_BIT 2
`define BSS_IRQ_W 3
`define BSS_IRQ_RESET 3'h0
`define BSS_RETAIN_RUN_BIT 0
`define BSS_RETAIN_LOCK_BIT 1
`define BSS_RUN_ENTER_BIT 0
`define BSS_RUN_STOP_BIT 1
`define BSS_RUN_LOCK_BIT 2
`endif

// *** src/bss_pkg.sv ***
// Types for the burner stopped-state sequencer
package bss_pkg;
  typedef enum logic [10:0] {
    BSS_POWER_ON = 11'h001,
    BSS_ALARM = 11'h002,
    BSS_READY = 11'h004,
    BSS_LOCKOUT = 11'h008,
    BSS_WAITING = 11'h010,
    BSS_STARTUP = 11'h020,
    BSS_PREPURGE = 11'h040,
    BSS_IGNITION = 11'h080,
    BSS_PILOT = 11'h100,
    BSS_LOW_FIRE = 11'h200,
    BSS_PROCESS = 11'h400
  } bss_state_t;
endpackage : bss_pkg

// *** src/bss_retain_if.sv ***
// Interface to the retained flag store
`timescale 1ns/1ns
interface bss_retain_if;
  logic wr_en;
  logic run_in;
  logic lock_in;
  logic run_q;
  logic lock_q;
  modport ctrl (output wr_en, output run_in, output lock_in, input run_q, input lock_q);
  modport store (input wr_en, input run_in, input lock_in, output run_q, output lock_q);
endinterface : bss_retain_if

// *** src/bss_retain_store.sv ***
// Retained flag store, not cleared by reset
`timescale 1ns/1ns
module bss_retain_store
  import bss_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  bss_retain_if.store rif
);
  logic run_reg;
  logic lock_reg;

  // No reset: contents must survive a power cycle
  always_ff @(posedge clk)
  begin
    if (clk_en && rif.wr_en)
    begin
      run_reg <= rif.run_in;
      lock_reg <= rif.lock_in;
    end
  end

  assign rif.run_q = run_reg;
  assign rif.lock_q = lock_reg;
endmodule : bss_retain_store

// *** src/bss_sequencer.sv ***
// Burner stopped-state sequencer top
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "bss_params.svh"
module bss_sequencer
  import bss_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic alarm_present,
  input wire logic user_start,
  input wire logic lockout_ack,
  input wire logic [`BSS_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic irq,
  output logic purge_req,
  output logic pilot_on,
  output logic first_main_shutoff_valve,
  output logic second_main_shutoff_valve,
  output logic card_valve_on,
  output logic card_coil_on,
  output logic ignition_enable_closed,
  output logic stopped_flag,
  output logic running_flag,
  output logic fuel_flag,
  output logic main_flag
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic [2:0] alarm_sync_reg;
  logic [2:0] start_sync_reg;
  logic [2:0] ack_sync_reg;
  logic alarm_s;
  logic start_rise;
  logic ack_rise;
  bss_state_t state_reg;
  bss_state_t state_next;
  logic [7:0] ctrl_reg;
  logic [`BSS_IRQ_W-1:0] irq_stat_reg;
  logic [`BSS_IRQ_W-1:0] irq_mask_reg;
  logic [`BSS_IRQ_W-1:0] irq_event;
  logic [7:0] rdata_reg;
  logic run_cmd_enter;
  logic run_cmd_stop;
  logic run_cmd_lock;
  logic entering;
  logic restart_en;
  logic stopped_c;
  bss_retain_if rif ();

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Pins: two flops, third stage only for edge detect
  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
    begin
      alarm_sync_reg <= 3'h0;
      start_sync_reg <= 3'h0;
      ack_sync_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      alarm_sync_reg <= {alarm_sync_reg[1:0], alarm_present};
      start_sync_reg <= {start_sync_reg[1:0], user_start};
      ack_sync_reg <= {ack_sync_reg[1:0], lockout_ack};
    end
  end

  assign alarm_s = alarm_sync_reg[1];
  assign start_rise = start_sync_reg[1] && !start_sync_reg[2];
  assign ack_rise = ack_sync_reg[1] && !ack_sync_reg[2];
  assign restart_en = ctrl_reg[`BSS_CTRL_RESTART_BIT];

  // Software stand-in for the running-side sequence, which lives elsewhere
  assign run_cmd_enter = wr_stb && (addr == `BSS_ADDR_RUN_CMD) && wdata[`BSS_RUN_ENTER_BIT];
  assign run_cmd_stop = wr_stb && (addr == `BSS_ADDR_RUN_CMD) && wdata[`BSS_RUN_STOP_BIT];
  assign run_cmd_lock = wr_stb && (addr == `BSS_ADDR_RUN_CMD) && wdata[`BSS_RUN_LOCK_BIT];

  function automatic logic is_stopped(input bss_state_t s);
    is_stopped = (s == BSS_POWER_ON) || (s == BSS_ALARM) || (s == BSS_READY)
      || (s == BSS_LOCKOUT);
  endfunction : is_stopped

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      BSS_POWER_ON:
      begin
        if (rif.lock_q)
          state_next = BSS_LOCKOUT;
        else if (alarm_s)
          state_next = BSS_READY;
        else if (restart_en && rif.run_q)
          state_next = BSS_WAITING;
        else
          state_next = BSS_READY;
      end
      BSS_READY:
      begin
        if (alarm_s)
          state_next = BSS_ALARM;
        else if (start_rise)
          state_next = BSS_WAITING;
      end
      BSS_ALARM:
      begin
        if (!alarm_s)
          state_next = BSS_READY;
      end
      BSS_LOCKOUT:
      begin
        if (ack_rise)
          state_next = BSS_READY;
      end
      default:
      begin
        // Running states: leave on the outer sequence's commands, or to Lockout on alarm_s
        if (run_cmd_lock || alarm_s)
          state_next = BSS_LOCKOUT;
        else if (run_cmd_stop)
          state_next = BSS_READY;
        else if (run_cmd_enter && state_reg == BSS_WAITING)
          state_next = BSS_STARTUP;
      end
    endcase
  end

  // Per-instance state, nothing shared
  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
      state_reg <= BSS_POWER_ON;
    else if (clk_en)
      state_reg <= state_next;
  end

  // Held off in reset so the store is not rewritten while Power On waits
  assign entering = clk_en && rst_s2_reg && (state_next != state_reg);

  // Retained flags follow the state
  assign rif.wr_en = entering;
  assign rif.run_in = !is_stopped(state_next);
  assign rif.lock_in = (state_next == BSS_LOCKOUT);

  bss_retain_store u_store (
    .clk(clk),
    .clk_en(clk_en),
    .rif(rif.store)
  );

  // Purge pulse on Lockout entry; Power On entry is the reset release itself
  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
      purge_req <= 1'b1;
    else if (clk_en)
      purge_req <= entering && (state_next == BSS_LOCKOUT);
  end

  assign stopped_c = is_stopped(state_reg);

  // Outputs only energize under the running sequence, never here
  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
    begin
      pilot_on <= 1'b0;
      first_main_shutoff_valve <= 1'b0;
      second_main_shutoff_valve <= 1'b0;
      card_valve_on <= 1'b0;
      card_coil_on <= 1'b0;
      ignition_enable_closed <= 1'b0;
    end
    else if (clk_en)
    begin
      pilot_on <= 1'b0;
      first_main_shutoff_valve <= 1'b0;
      second_main_shutoff_valve <= 1'b0;
      card_valve_on <= 1'b0;
      card_coil_on <= 1'b0;
      ignition_enable_closed <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
    begin
      stopped_flag <= 1'b1;
      running_flag <= 1'b0;
      fuel_flag <= 1'b0;
      main_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      stopped_flag <= is_stopped(state_next);
      running_flag <= !is_stopped(state_next);
      fuel_flag <= (state_next == BSS_IGNITION) || (state_next == BSS_PILOT)
        || (state_next == BSS_LOW_FIRE) || (state_next == BSS_PROCESS);
      main_flag <= (state_next == BSS_LOW_FIRE) || (state_next == BSS_PROCESS);
    end
  end

  // Control register; no reset, the restart setting must outlive power loss
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_stb && addr == `BSS_ADDR_CTRL)
      ctrl_reg <= wdata;
  end

  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
      irq_mask_reg <= `BSS_IRQ_RESET;
    else if (clk_en && wr_stb && addr == `BSS_ADDR_IRQ_MASK)
      irq_mask_reg <= wdata[`BSS_IRQ_W-1:0];
  end

  always_comb
  begin
    irq_event = `BSS_IRQ_RESET;
    irq_event[`BSS_IRQ_PURGE_BIT] = purge_req;
    irq_event[`BSS_IRQ_STATE_BIT] = entering;
    irq_event[`BSS_IRQ_ALARM_BIT] = entering && (state_next == BSS_ALARM);
  end

  // Set wins over the read-clear
  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
      irq_stat_reg <= `BSS_IRQ_RESET;
    else if (clk_en)
    begin
      if (rd_stb && addr == `BSS_ADDR_IRQ_STAT)
        irq_stat_reg <= irq_event;
      else
        irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
      rdata_reg <= 8'h00;
    else if (clk_en)
    begin
      rdata_reg <= 8'h00;
      if (rd_stb)
      begin
        unique case (addr)
          `BSS_ADDR_CTRL: rdata_reg <= ctrl_reg;
          `BSS_ADDR_STATUS: rdata_reg <= {4'h0, main_flag, fuel_flag, running_flag, stopped_c};
          `BSS_ADDR_IRQ_STAT: rdata_reg <= {5'h00, irq_stat_reg};
          `BSS_ADDR_IRQ_MASK: rdata_reg <= {5'h00, irq_mask_reg};
          `BSS_ADDR_RETAIN: rdata_reg <= {6'h00, rif.lock_q, rif.run_q};
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign rdata = rdata_reg;
endmodule : bss_sequencer

// *** verification/bss_operator.sv ***
// Operator panel model: start and acknowledge pulses
`timescale 1ns/1ns
module bss_operator
(
  input wire logic clk,
  input wire logic start_req,
  input wire logic ack_req,
  output logic user_start,
  output logic lockout_ack
);
  logic [2:0] s_reg = 3'h0;
  logic [2:0] a_reg = 3'h0;
  // Held three cycles so the input sync surely sees the edge
  always_ff @(posedge clk)
  begin
    s_reg <= {s_reg[1:0], start_req};
    a_reg <= {a_reg[1:0], ack_req};
  end
  assign user_start = |s_reg;
  assign lockout_ack = |a_reg;
endmodule : bss_operator

// *** verification/bss_sequencer_monitor.sv ***
// Checker for the stopped-state sequencer ports
`timescale 1ns/1ns
`include "bss_params.svh"
module bss_sequencer_monitor
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`BSS_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic alarm_present,
  input wire logic purge_req,
  input wire logic pilot_on,
  input wire logic first_main_shutoff_valve,
  input wire logic second_main_shutoff_valve,
  input wire logic card_valve_on,
  input wire logic card_coil_on,
  input wire logic ignition_enable_closed,
  input wire logic stopped_flag,
  input wire logic running_flag,
  input wire logic fuel_flag,
  input wire logic main_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_VALVES: assert property (stopped_flag |-> !(pilot_on | first_main_shutoff_valve |
    second_main_shutoff_valve | card_valve_on | card_coil_on)) else $error("valve on");
  AST_IGN: assert property (stopped_flag |-> !ignition_enable_closed)
    else $error("ignition closed");
  AST_CLASS: assert property (stopped_flag != running_flag) else $error("class");
  AST_FUEL: assert property (fuel_flag |-> running_flag) else $error("fuel");
  AST_MAIN: assert property (main_flag |-> fuel_flag) else $error("main");
  // Alarm seen long enough to pass the sync must keep the burner stopped
  AST_HOLD: assert property (alarm_present [*4] ##0 stopped_flag |=> stopped_flag)
    else $error("left alarm");
  AST_PURGE_UP: assert property ($rose(rstn) |-> purge_req ##[1:6] !purge_req)
    else $error("power-up purge");
  AST_LOCK_PURGE: assert property (wr_stb && addr == `BSS_ADDR_RUN_CMD &&
    wdata[`BSS_RUN_LOCK_BIT] && running_flag |-> ##[1:3] purge_req) else $error("lock purge");
endmodule : bss_sequencer_monitor
bind bss_sequencer bss_sequencer_monitor bss_sequencer_monitor_i (.clk(clk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .alarm_present(alarm_present),
  .purge_req(purge_req), .pilot_on(pilot_on), .first_main_shutoff_valve(first_main_shutoff_valve),
  .second_main_shutoff_valve(second_main_shutoff_valve), .card_valve_on(card_valve_on),
  .card_coil_on(card_coil_on), .ignition_enable_closed(ignition_enable_closed),
  .stopped_flag(stopped_flag), .running_flag(running_flag), .fuel_flag(fuel_flag),
  .main_flag(main_flag));

// *** verification/test_burner_stopped_state_sequencer.sv ***
// Self-checking bench for the stopped-state sequencer
`timescale 1ns/1ns
`include "bss_params.svh"
module test_burner_stopped_state_sequencer;
  logic clk = 0;
  logic rstn = 0;
  logic alarm = 0;
  logic sreq = 0;
  logic areq = 0;
  logic rd_stb = 0;
  logic wr_stb = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] d;
  logic [7:0] rdata;
  logic irq, run, ustart, uack;
  int fails = 0;
  int n_tests = 0;
  bss_sequencer bss_sequencer_i (.clk(clk), .rstn(rstn), .clk_en(1'b1), .alarm_present(alarm),
    .user_start(ustart), .lockout_ack(uack), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .purge_req(), .pilot_on(),
    .first_main_shutoff_valve(), .second_main_shutoff_valve(), .card_valve_on(),
    .card_coil_on(), .ignition_enable_closed(), .stopped_flag(), .running_flag(run),
    .fuel_flag(), .main_flag());
  bss_operator bss_operator_i (.clk(clk), .start_req(sreq), .ack_req(areq),
    .user_start(ustart), .lockout_ack(uack));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task summarize;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task op(input logic s);
    @(posedge clk);
    sreq <= s;
    areq <= !s;
    @(posedge clk);
    sreq <= 1'b0;
    areq <= 1'b0;
  endtask : op
  task set_alarm(input logic v);
    @(posedge clk);
    alarm <= v;
    cyc(6);
  endtask : set_alarm
  // Bounded wait; a hang ends the run as a failure
  task wt(input logic v);
    int i;
    for (i = 0; i < 40 && run !== v; i++) cyc(1);
    chk(run, v);
    if (run !== v) summarize();
  endtask : wt
  task pwr;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    cyc(6);
  endtask : pwr
  task run_cmd(input logic [7:0] c);
    op(1);
    wt(1);
    wr(`BSS_ADDR_RUN_CMD, c);
    wt(0);
  endtask : run_cmd
  task t_boot;
    rd(`BSS_ADDR_STATUS);
    chk(d, 8'h01);
    rd(`BSS_ADDR_IRQ_STAT);
    chk(d & 8'h01, 8'h01);
    rd(`BSS_ADDR_IRQ_STAT);
    chk(d, 8'h00);
    rd(4'hf);
    chk(d, 8'h00);
    op(1);
    wt(1);
    rd(`BSS_ADDR_STATUS);
    chk(d, 8'h02);
    wr(`BSS_ADDR_RUN_CMD, 8'h02);
    wt(0);
    $display("t_boot done");
  endtask : t_boot
  task t_alarm;
    wr(`BSS_ADDR_IRQ_MASK, 8'h04);
    set_alarm(1);
    chk(irq, 1);
    rd(`BSS_ADDR_IRQ_STAT);
    chk(d & 8'h04, 8'h04);
    cyc(2);
    chk(irq, 0);
    op(1);
    cyc(8);
    chk(run, 0);
    set_alarm(0);
    run_cmd(8'h02);
    $display("t_alarm done");
  endtask : t_alarm
  task t_lock;
    run_cmd(8'h04);
    rd(`BSS_ADDR_RETAIN);
    chk(d & 8'h02, 8'h02);
    op(1);
    cyc(8);
    chk(run, 0);
    op(0);
    cyc(6);
    run_cmd(8'h02);
    $display("t_lock done");
  endtask : t_lock
  task t_pwr;
    run_cmd(8'h04);
    pwr();
    chk(irq, 0);
    op(1);
    cyc(8);
    chk(run, 0);
    op(0);
    cyc(6);
    set_alarm(1);
    pwr();
    rd(`BSS_ADDR_IRQ_STAT);
    chk(d & 8'h04, 8'h04);
    set_alarm(0);
    op(1);
    wt(1);
    pwr();
    chk(run, 0);
    run_cmd(8'h02);
    $display("t_pwr done");
  endtask : t_pwr
  task t_restart;
    wr(`BSS_ADDR_CTRL, 8'h01);
    pwr();
    rd(`BSS_ADDR_CTRL);
    chk(d, 8'h01);
    chk(run, 0);
    op(1);
    wt(1);
    pwr();
    chk(run, 1);
    wr(`BSS_ADDR_RUN_CMD, 8'h02);
    wt(0);
    wr(`BSS_ADDR_CTRL, 8'h00);
    $display("t_restart done");
  endtask : t_restart
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    cyc(6);
    t_boot();
    t_alarm();
    t_lock();
    t_pwr();
    t_restart();
    summarize();
  end
endmodule : test_burner_stopped_state_sequencer
